// ---- ifst_cfg_top.sv ----
/*
 * input floor and safety timer configuration register with the
 * safety timer it steers.
 * assumes the serial engine delivers one-cycle register strobes on
 * mclk_i, and that charger status levels arrive asynchronously.
 */
// Operation
// - register sits at offset 0x0b and resets to 0x4a.
// - bit 7 set disables input floor regulation, clear enables it.
// - bits 6:4 code; threshold is 4200 mV plus code times 100 mV.
// - bit 3 set halves timer rate outside constant current or voltage.
// - bits 2:1 pick 30 minutes, 3 hours, 9 hours, or timers off.
// - defaults hold until the host writes new values.
// - global register reset pulse returns this register to its default.
module ifst_cfg_top
	import ifst_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = IFST_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	// register port from the serial engine
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        global_reg_reset_i,
	output logic [7:0]       reg_rdata_o,
	// charger status, asynchronous
	input  wire logic        charge_active_i,
	input  wire logic        loop_cc_cv_i,
	// configuration outputs
	output logic             input_floor_enable_o,
	output logic [12:0]      input_floor_mv_o,
	output logic             timer_halfrate_enable_o,
	output logic [1:0]       safety_limit_select_o,
	output logic             safety_expired_o
);

	ifst_cfg_t   cfg_r;
	logic [7:0]  rdata_r;
	logic [12:0] floor_mv_r;
	logic [2:0]  act_sync_r;
	logic [2:0]  loop_sync_r;
	logic        act_r;
	logic        loop_r;
	logic        cfg_hit;
	logic        timer_run;
	logic        timer_slow;

	assign cfg_hit = (reg_addr_i == IFST_CFG_OFFSET);

	// ----------------------------------------------------------------
	// configuration register
	// ----------------------------------------------------------------
	// global reset takes priority so a combined write cannot survive it
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_r <= ifst_cfg_t'(IFST_CFG_RESET);
		end else if (global_reg_reset_i) begin
			cfg_r <= ifst_cfg_t'(IFST_CFG_RESET);
		end else if (reg_wr_i && cfg_hit) begin
			cfg_r <= ifst_cfg_t'(reg_wdata_i);
		end
	end

	// ----------------------------------------------------------------
	// read data, unmapped offsets read as zero
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_i) begin
			if (cfg_hit)
				rdata_r <= cfg_r;
			else
				rdata_r <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// threshold arithmetic
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			floor_mv_r <= IFST_FLOOR_BASE_MV;
		else
			floor_mv_r <= IFST_FLOOR_BASE_MV
				+ 13'(cfg_r.input_floor_threshold) * IFST_FLOOR_STEP_MV;
	end

	// ----------------------------------------------------------------
	// status synchronisers
	// ----------------------------------------------------------------
	// a change is accepted only when stages two and three agree
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			act_sync_r  <= 3'h0;
			loop_sync_r <= 3'h0;
			act_r       <= 1'b0;
			loop_r      <= 1'b0;
		end else begin
			act_sync_r  <= {act_sync_r[1:0], charge_active_i};
			loop_sync_r <= {loop_sync_r[1:0], loop_cc_cv_i};
			if (act_sync_r[1] == act_sync_r[2])
				act_r <= act_sync_r[2];
			if (loop_sync_r[1] == loop_sync_r[2])
				loop_r <= loop_sync_r[2];
		end
	end

	// ----------------------------------------------------------------
	// safety timer
	// ----------------------------------------------------------------
	assign timer_run  = act_r && (cfg_r.safety_limit_select != IFST_LIMIT_OFF);
	assign timer_slow = cfg_r.timer_halfrate_enable && !loop_r;

	ifst_safety_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.run_i       (timer_run),
		.slow_i      (timer_slow),
		.limit_sel_i (cfg_r.safety_limit_select),
		.expired_o   (safety_expired_o),
		.elapsed_o   ()
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o             = rdata_r;
	assign input_floor_enable_o    = !cfg_r.input_floor_disable;
	assign input_floor_mv_o        = floor_mv_r;
	assign timer_halfrate_enable_o = cfg_r.timer_halfrate_enable;
	assign safety_limit_select_o   = cfg_r.safety_limit_select;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_cfg_write;
		reg_wr_i && cfg_hit && !global_reg_reset_i;
	endsequence

	sequence s_cfg_read;
		reg_rd_i && cfg_hit;
	endsequence

	property p_global_reset;
		@(posedge mclk_i) disable iff (!reset_n_i)
		global_reg_reset_i |=> (cfg_r == ifst_cfg_t'(IFST_CFG_RESET));
	endproperty
	a_global_reset: assert property (p_global_reset)
		else $error("global reset did not restore default");

	property p_write_lands;
		@(posedge mclk_i) disable iff (!reset_n_i)
		s_cfg_write |=> (cfg_r == ifst_cfg_t'($past(reg_wdata_i)));
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("write to config register not stored");

	property p_hold_without_write;
		@(posedge mclk_i) disable iff (!reset_n_i)
		!(reg_wr_i && cfg_hit) && !global_reg_reset_i |=> $stable(cfg_r);
	endproperty
	a_hold_without_write: assert property (p_hold_without_write)
		else $error("config register changed without a write");

	property p_floor_gate;
		@(posedge mclk_i) disable iff (!reset_n_i)
		s_cfg_write ##1 1'b1 |-> (input_floor_enable_o == !$past(reg_wdata_i[IFST_FLOOR_DIS_POS]));
	endproperty
	a_floor_gate: assert property (p_floor_gate)
		else $error("floor enable does not follow bit 7");

	property p_threshold;
		@(posedge mclk_i) disable iff (!reset_n_i)
		s_cfg_write ##1 !global_reg_reset_i && !(reg_wr_i && cfg_hit)
		|=> (input_floor_mv_o == IFST_FLOOR_BASE_MV
			+ 13'($past(reg_wdata_i[6:4], 2)) * IFST_FLOOR_STEP_MV);
	endproperty
	a_threshold: assert property (p_threshold)
		else $error("threshold arithmetic wrong");

	property p_no_slow_when_off;
		@(posedge mclk_i) disable iff (!reset_n_i)
		!timer_halfrate_enable_o |-> !timer_slow;
	endproperty
	a_no_slow_when_off: assert property (p_no_slow_when_off)
		else $error("timer slowed while halfrate disabled");

	property p_disabled_never_expires;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(safety_limit_select_o == IFST_LIMIT_OFF) [*2] |-> !safety_expired_o;
	endproperty
	a_disabled_never_expires: assert property (p_disabled_never_expires)
		else $error("safety timer expired while disabled");

	property p_readback;
		@(posedge mclk_i) disable iff (!reset_n_i)
		s_cfg_read |=> (reg_rdata_o == $past(cfg_r));
	endproperty
	a_readback: assert property (p_readback)
		else $error("readback differs from register");

endmodule

// ---- ifst_host_model.sv ----
/*
 * host side model: issues decoded register strobes, one per access.
 * assumes the serial engine upstream has already framed each byte.
 */
module ifst_host_model (
	// clock
	input  wire logic  mclk_i,
	// register strobes
	output logic [7:0] reg_addr_o,
	output logic       reg_wr_o,
	output logic       reg_rd_o,
	output logic [7:0] reg_wdata_o,
	output logic       global_reg_reset_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o, global_reg_reset_o} = '0;
	end
	// strobes held across exactly one rising edge
	task automatic access(input logic w, r, g, input logic [7:0] a, d);
		@(negedge mclk_i);
		{reg_wr_o, reg_rd_o, global_reg_reset_o, reg_addr_o, reg_wdata_o} = {w, r, g, a, d};
		@(negedge mclk_i);
		{reg_wr_o, reg_rd_o, global_reg_reset_o} = 3'h0;
		// released lines must not look like a held request
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
endmodule

// ---- ifst_pkg.sv ----
/*
 * shared constants and types for the input floor and safety timer
 * configuration block.
 * assumes a 40 MHz core clock and an upstream serial engine
 * that hands over decoded register accesses.
 */
package ifst_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IFST_CFG_OFFSET = 8'h0b;
	localparam logic [7:0] IFST_CFG_RESET  = 8'h4a;

	// field positions
	localparam int IFST_FLOOR_DIS_POS  = 7;
	localparam int IFST_FLOOR_CODE_LSB = 4;
	localparam int IFST_HALFRATE_POS   = 3;
	localparam int IFST_LIMIT_LSB      = 1;
	localparam int IFST_SPARE_POS      = 0;

	// ----------------------------------------------------------------
	// threshold arithmetic, millivolts
	// ----------------------------------------------------------------
	localparam logic [12:0] IFST_FLOOR_BASE_MV = 13'h1068;
	localparam logic [12:0] IFST_FLOOR_STEP_MV = 13'h0064;

	// ----------------------------------------------------------------
	// safety limit encodings and durations in seconds
	// ----------------------------------------------------------------
	localparam logic [1:0]  IFST_LIMIT_30M  = 2'h0;
	localparam logic [1:0]  IFST_LIMIT_3H   = 2'h1;
	localparam logic [1:0]  IFST_LIMIT_9H   = 2'h2;
	localparam logic [1:0]  IFST_LIMIT_OFF  = 2'h3;
	localparam logic [14:0] IFST_SECS_30M   = 15'h0708;
	localparam logic [14:0] IFST_SECS_3H    = 15'h2a30;
	localparam logic [14:0] IFST_SECS_9H    = 15'h7e90;

	// ----------------------------------------------------------------
	// timing: one timer tick is one second
	// ----------------------------------------------------------------
	localparam int IFST_CLK_NS      = 25;
	localparam int IFST_TICK_S      = 1;
	localparam int IFST_TICK_CYCLES = IFST_TICK_S * 1000000000 / IFST_CLK_NS;

	// ----------------------------------------------------------------
	// configuration carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       input_floor_disable;
		logic [2:0] input_floor_threshold;
		logic       timer_halfrate_enable;
		logic [1:0] safety_limit_select;
		logic       spare;
	} ifst_cfg_t;

endpackage

// ---- ifst_safety_timer.sv ----
/*
 * fast charge safety timer with optional half rate advance.
 * assumes run_i already folds in the disable encoding and that
 * slow_i is synchronous to mclk_i.
 */
module ifst_safety_timer
	import ifst_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = IFST_TICK_CYCLES
) (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	// control
	input  wire logic       run_i,
	input  wire logic       slow_i,
	input  wire logic [1:0] limit_sel_i,
	// status
	output logic            expired_o,
	output logic [14:0]     elapsed_o
);

	logic [25:0] pre_r;
	logic        phase_r;
	logic [14:0] secs_r;
	logic        expired_r;
	logic        tick;
	logic        adv;
	logic [14:0] limit_secs;

	assign tick = (pre_r == 26'(TICK_CYCLES - 1));
	// slowed mode only advances on every second tick
	assign adv  = tick && (!slow_i || phase_r);

	always_comb begin
		case (limit_sel_i)
			IFST_LIMIT_30M: limit_secs = IFST_SECS_30M;
			IFST_LIMIT_3H:  limit_secs = IFST_SECS_3H;
			default:        limit_secs = IFST_SECS_9H;
		endcase
	end

	// ----------------------------------------------------------------
	// prescaler and phase
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_r   <= 26'h0;
			phase_r <= 1'b0;
		end else if (!run_i) begin
			pre_r   <= 26'h0;
			phase_r <= 1'b0;
		end else if (tick) begin
			pre_r   <= 26'h0;
			phase_r <= ~phase_r;
		end else begin
			pre_r   <= pre_r + 26'h1;
		end
	end

	// ----------------------------------------------------------------
	// elapsed seconds and sticky expiry
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			secs_r    <= 15'h0;
			expired_r <= 1'b0;
		end else if (!run_i) begin
			secs_r    <= 15'h0;
			expired_r <= 1'b0;
		end else begin
			if (adv && !expired_r)
				secs_r <= secs_r + 15'h1;
			if (secs_r >= limit_secs)
				expired_r <= 1'b1;
		end
	end

	assign expired_o = expired_r;
	assign elapsed_o = secs_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_full_rate;
		@(posedge mclk_i) disable iff (!reset_n_i)
		run_i && tick && !slow_i && !expired_r |=> (secs_r == $past(secs_r) + 15'h1);
	endproperty
	a_full_rate: assert property (p_full_rate)
		else $error("timer skipped a tick at full rate");

	property p_half_rate;
		@(posedge mclk_i) disable iff (!reset_n_i)
		run_i && tick && slow_i && !phase_r |=> $stable(secs_r);
	endproperty
	a_half_rate: assert property (p_half_rate)
		else $error("slowed timer advanced on the skipped tick");

	property p_expire;
		@(posedge mclk_i) disable iff (!reset_n_i)
		run_i && !expired_r && (secs_r >= limit_secs) |=> expired_r;
	endproperty
	a_expire: assert property (p_expire)
		else $error("timer reached its limit without expiring");

endmodule

// ---- test_input_floor_and_safety_timer_cfg.sv ----
/*
 * self-checking bench for the configuration register and its timer.
 * assumes a shortened tick of 4 cycles so the 30 minute and 3 hour limits fit in the run.
 */
module test_input_floor_and_safety_timer_cfg
	import ifst_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk_i, reset_n_i, charge_active_i, loop_cc_cv_i;
	logic        reg_wr_i, reg_rd_i, global_reg_reset_i, safety_expired_o;
	logic        input_floor_enable_o, timer_halfrate_enable_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, m, s;
	logic [12:0] input_floor_mv_o;
	logic [1:0]  safety_limit_select_o;
	int          err_total, cmp_count;
	localparam int TK = 4;
	// ----------------------------------------------------------------
	// parts
	// ----------------------------------------------------------------
	ifst_host_model host (.mclk_i(mclk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .global_reg_reset_o(global_reg_reset_i));
	ifst_cfg_top #(.TICK_CYCLES(TK)) dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .global_reg_reset_i(global_reg_reset_i),
		.reg_rdata_o(reg_rdata_o), .charge_active_i(charge_active_i),
		.loop_cc_cv_i(loop_cc_cv_i), .input_floor_enable_o(input_floor_enable_o),
		.input_floor_mv_o(input_floor_mv_o),
		.timer_halfrate_enable_o(timer_halfrate_enable_o),
		.safety_limit_select_o(safety_limit_select_o), .safety_expired_o(safety_expired_o));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic results();
		if (err_total == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_reg(input string n, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_out(input string n, input logic [12:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cfg_check();
		chk_out("enable", {12'h000, ~m[7]}, {12'h000, input_floor_enable_o});
		chk_out("mv", 13'h1068 + 13'h0064 * m[6:4], input_floor_mv_o);
		chk_out("halfrate", {12'h000, m[3]}, {12'h000, timer_halfrate_enable_o});
		chk_out("limit", {11'h000, m[2:1]}, {11'h000, safety_limit_select_o});
	endtask
	task automatic rd(input logic [7:0] a, e);
		host.access(1'b0, 1'b1, 1'b0, a, 8'h00);
		chk_reg("rdata", e, reg_rdata_o);
	endtask
	task automatic wr(input logic [7:0] a, d);
		host.access(1'b1, 1'b0, 1'b0, a, d);
		if (a == IFST_CFG_OFFSET) begin
			m = d;
		end
		// threshold lags the register by one cycle
		@(negedge mclk_i);
		cfg_check();
	endtask
	task automatic rst();
		reset_n_i = 1'b0;
		repeat (10) @(negedge mclk_i);
		reset_n_i = 1'b1;
		m = 8'h4a;
	endtask
	// limit in cycles from the model; 16 cycles of slack cover sync latency
	task automatic tmr(input logic [7:0] v, input logic lp, input int lim);
		int   cyc;
		logic e;
		wr(IFST_CFG_OFFSET, v);
		cyc = (v[2:1] == IFST_LIMIT_30M) ? int'(IFST_SECS_30M) :
			(v[2:1] == IFST_LIMIT_3H) ? int'(IFST_SECS_3H) : int'(IFST_SECS_9H);
		cyc = cyc * TK * ((v[3] && !lp) ? 2 : 1);
		e = (v[2:1] != IFST_LIMIT_OFF) && (cyc <= lim);
		loop_cc_cv_i = lp;
		charge_active_i = 1'b1;
		repeat ((cyc < lim) ? cyc : lim) @(negedge mclk_i);
		chk_out("early", 13'h0000, {12'h000, safety_expired_o});
		for (int i = 0; i < 16 && safety_expired_o !== 1'b1; i++) @(negedge mclk_i);
		chk_out("expired", {12'h000, e}, {12'h000, safety_expired_o});
		charge_active_i = 1'b0;
		repeat (8) @(negedge mclk_i);
		chk_out("cleared", 13'h0000, {12'h000, safety_expired_o});
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (90000) @(posedge mclk_i);
		err_total++;
		results();
	end
	initial begin
		{reset_n_i, charge_active_i, loop_cc_cv_i, err_total, cmp_count} = '0;
		loop_cc_cv_i = 1'b1;
		s = 8'h38;
		rst();
		@(negedge mclk_i);
		cfg_check();
		rd(IFST_CFG_OFFSET, 8'h4a);
		for (int i = 0; i < 8; i++) begin
			s = lfsr(s);
			wr(IFST_CFG_OFFSET, {s[7:3], i[1:0], s[0]});
			rd(IFST_CFG_OFFSET, m);
		end
		wr(8'h0c, 8'h55);
		rd(8'h0c, 8'h00);
		rd(IFST_CFG_OFFSET, m);
		// write dropped when global reset lands in the same cycle
		host.access(1'b1, 1'b0, 1'b1, IFST_CFG_OFFSET, 8'h00);
		m = 8'h4a;
		@(negedge mclk_i);
		cfg_check();
		rd(IFST_CFG_OFFSET, 8'h4a);
		wr(IFST_CFG_OFFSET, 8'hb5);
		rst();
		rd(IFST_CFG_OFFSET, 8'h4a);
		tmr(8'h08, 1'b1, 50000);
		tmr(8'h08, 1'b0, 50000);
		tmr(8'h06, 1'b0, 7400);
		tmr(8'h02, 1'b0, 50000);
		tmr(8'h04, 1'b1, 7400);
		results();
	end
endmodule
